/* rtl/fws_defines.vh */
// register map, control bit layout, operation codes and timing counts of the
// flash write sequencer; assumes it is included once per design file
`ifndef FWS_DEFINES_VH
`define FWS_DEFINES_VH

// register byte offsets on the axi4-lite port, one aligned word each
`define FWS_A_CTRL_LO   8'h00
`define FWS_A_CTRL_HI   8'h04
`define FWS_A_SEC_LO    8'h08
`define FWS_A_SEC_HI    8'h0c
`define FWS_A_ADDR_LO   8'h10
`define FWS_A_ADDR_HI   8'h14
`define FWS_A_D0_LO     8'h18
`define FWS_A_D0_HI     8'h1c
`define FWS_A_D1_LO     8'h20
`define FWS_A_D1_HI     8'h24
`define FWS_A_ERR       8'h28
`define FWS_A_STAT      8'h2c
`define FWS_A_NV_WP_LO  8'h30
`define FWS_A_NV_WP_HI  8'h34
`define FWS_A_NV_AP0    8'h38
`define FWS_A_NV_DIS    8'h3c
`define FWS_A_NV_REN    8'h40

// op_ctrl_high bit positions and masks
`define FWS_B_START     15
`define FWS_B_SUSPEND_REQ      14
`define FWS_B_WPG       13
`define FWS_B_DWORD_PROG_SEL      12
`define FWS_B_SER       11
`define FWS_B_SPR       8
`define FWS_B_ARRAY_MODE_SEL      7
`define FWS_M_START     16'h8000
`define FWS_M_SUSPEND_REQ      16'h4000
`define FWS_M_SER       16'h0800
`define FWS_M_OPSEL     16'h3900

// error flag and target address bit positions
`define FWS_B_ERR_RES   0
`define FWS_ADDR_BIT2   2

// operation codes
`define FWS_OP_NONE     3'h0
`define FWS_OP_WORD     3'h1
`define FWS_OP_DWORD    3'h2
`define FWS_OP_ERASE    3'h3
`define FWS_OP_SPR      3'h4

// protection register addresses seen through target_addr_low
`define FWS_NV_WP_ADDR  16'hdfb4
`define FWS_NV_AP0_ADDR 16'hdfb8
`define FWS_NV_AP1_ADDR 16'hdfbc

// reset values
`define FWS_RST_REG     16'h0000
`define FWS_RST_NV      16'hffff

// operation timing in clock cycles
`define FWS_PROG_CYCLES  16
`define FWS_ERASE_CYCLES 64

// axi responses
`define FWS_RESP_OKAY   2'b00
`define FWS_RESP_SLVERR 2'b10

`endif

/* rtl/fws_reset_sync.v */
// reset release synchroniser for the flash write sequencer
// assumes nrst may drop at any time; release is aligned to clk
`include "fws_defines.vh"

module fws_reset_sync (
	input  wire clk,
	input  wire nrst,
	output wire rst_n
);
	reg meta_reg;
	reg sync_reg;

	// assert at once, release after two edges to avoid a metastable release
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= 1'b1;
			sync_reg <= meta_reg;
		end
	end

	assign rst_n = sync_reg;
endmodule // fws_reset_sync

/* rtl/fws_nv_protect.v */
// model of the non-volatile protection registers written by set protection
// assumes one write strobe per finished set-protection operation
`include "fws_defines.vh"

module fws_nv_protect (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wr_stb,
	input  wire [15:0] wr_addr,
	input  wire [15:0] wr_dlo,
	input  wire [15:0] wr_dhi,
	output reg  [31:0] nv_write_protect_reg,
	output reg  [15:0] nv_access_protect_reg,
	output reg  [15:0] nv_protect_disable_reg,
	output reg  [15:0] nv_protect_reenable_reg,
	output wire        acc_on,
	output wire        dbg_on
);
	wire [15:0] dis_ok;
	wire [15:0] dis_next;
	wire [15:0] en_next;
	wire        perm_off;

	// disable bit x needs re-enable bit x-1 at 0; bit 0 needs both protections set
	assign dis_ok   = {~nv_protect_reenable_reg[14:0],
		nv_access_protect_reg[1:0] == 2'b00};
	assign dis_next = nv_protect_disable_reg & ~(~wr_dlo & dis_ok);
	// a re-enable bit may only fall once its own disable bit has fallen
	assign en_next  = nv_protect_reenable_reg & ~(~wr_dhi & ~nv_protect_disable_reg);
	// sixteen bit pairs give at most sixteen disable/re-enable rounds
	assign perm_off = |(~nv_protect_disable_reg & nv_protect_reenable_reg);
	assign acc_on   = ~nv_access_protect_reg[0] & ~perm_off;
	assign dbg_on   = ~nv_access_protect_reg[1] & ~perm_off;

	// flash cells only program towards 0; reset restores the delivery value
	// in simulation only, real cells would keep their content
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_write_protect_reg    <= {`FWS_RST_NV, `FWS_RST_NV};
			nv_access_protect_reg   <= `FWS_RST_NV;
			nv_protect_disable_reg  <= `FWS_RST_NV;
			nv_protect_reenable_reg <= `FWS_RST_NV;
		end
		else if (wr_stb)
		begin
			case (wr_addr)
				`FWS_NV_WP_ADDR:
					nv_write_protect_reg <= nv_write_protect_reg & {wr_dhi, wr_dlo};
				`FWS_NV_AP0_ADDR:
					nv_access_protect_reg <= nv_access_protect_reg & wr_dlo;
				`FWS_NV_AP1_ADDR:
				begin
					nv_protect_disable_reg  <= dis_next;
					nv_protect_reenable_reg <= en_next;
				end
				default:
					nv_access_protect_reg <= nv_access_protect_reg;
			endcase
		end
	end
endmodule // fws_nv_protect

/* rtl/fws_flash_seq.v */
// flash write sequencer: program, erase, set protection, suspend and resume
// assumes an axi4-lite master and a flash array that takes one-cycle strobes
//
// Behaviour
// - every register write is taken as a 16-bit half-register access
// - select an operation, load address/data or sectors, then set start
// - clearing a select bit before start cancels the operation
// - bit 15 starts or resumes; 0x2080 selects word program
// - word program writes 32 bits from data pair 0 to the target address
// - double word program writes 64 bits, address bit 2 ignored
// - 0x0880 selects sector erase, one sector_sel bit per sector
// - suspend bit suspends a running program or sector erase
// - changed select bits at resume abort and set the resume error flag
// - a suspended erase allows a program of another sector
// - program inside erase suspend keeps erase/suspend low, cannot suspend
// - 0x0100 selects set protection into the addressed protection register
// - 0xfffc at 0xdfb8 programs access and debug protection on
// - 0xfffe at 0xdfbc clears first disable (low) or re-enable (high) bit
// - permanent disable and re-enable possible at most sixteen times
// - disable bit x programmable only after re-enable bit x-1
//
// Our own choices: the address map and the AXI4-Lite slave port.
`include "fws_defines.vh"

module fws_flash_seq #(
	parameter PROG_CYCLES  = `FWS_PROG_CYCLES,
	parameter ERASE_CYCLES = `FWS_ERASE_CYCLES
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	output reg         fl_prog_stb,
	output reg         fl_dword,
	output reg  [31:0] fl_addr,
	output reg  [63:0] fl_data,
	output reg         fl_erase_stb,
	output reg  [4:0]  fl_erase_sector,
	output reg         busy,
	output reg         acc_prot_on,
	output reg         dbg_prot_on
);
	localparam [6:0] S_IDLE  = 7'b0000001;
	localparam [6:0] S_PROG  = 7'b0000010;
	localparam [6:0] S_ERASE = 7'b0000100;
	localparam [6:0] S_SPR   = 7'b0001000;
	localparam [6:0] S_ESUSP = 7'b0010000;
	localparam [6:0] S_PSUSP = 7'b0100000;
	localparam [6:0] S_PES   = 7'b1000000;
	localparam integer PROG_LAST  = PROG_CYCLES - 1;
	localparam integer ERASE_LAST = ERASE_CYCLES - 1;

	wire        rst_n;
	reg  [7:0]  awaddr_reg;
	reg  [15:0] wdata_reg;
	reg  [1:0]  wstrb_reg;
	reg  [15:0] op_ctrl_low_reg;
	reg  [15:0] op_ctrl_high_reg;
	reg  [15:0] sector_sel_low_reg;
	reg  [15:0] sector_sel_high_reg;
	reg  [15:0] target_addr_low_reg;
	reg  [15:0] target_addr_high_reg;
	reg  [15:0] wdata0_low_reg;
	reg  [15:0] wdata0_high_reg;
	reg  [15:0] wdata1_low_reg;
	reg  [15:0] wdata1_high_reg;
	reg  [15:0] error_reg;
	reg  [15:0] saved_sel_reg;
	reg         prog_dw_reg;
	reg  [6:0]  state_reg;
	reg  [15:0] cnt_reg;
	reg         prot_wr_reg;
	reg  [31:0] rd_data;
	reg         rd_ok;
	wire [31:0] nv_wp;
	wire [15:0] nv_ap0;
	wire [15:0] nv_dis;
	wire [15:0] nv_ren;
	wire        prot_acc;
	wire        prot_dbg;
	wire        wr_fire;
	wire        hi_wr;
	wire [15:0] hv;
	wire [15:0] st_sel;
	wire [2:0]  st_op;
	wire [31:0] sec_all;
	wire [3:0]  stat;

	// byte-lane merge of a 16-bit half-register write
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] d;
		input [1:0]  s;
		begin
			merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	// operation encoded by the select bits, program first
	function [2:0] op_dec;
		input [15:0] v;
		begin
			if (v[`FWS_B_WPG])
				op_dec = `FWS_OP_WORD;
			else if (v[`FWS_B_DWORD_PROG_SEL])
				op_dec = `FWS_OP_DWORD;
			else if (v[`FWS_B_SER])
				op_dec = `FWS_OP_ERASE;
			else if (v[`FWS_B_SPR])
				op_dec = `FWS_OP_SPR;
			else
				op_dec = `FWS_OP_NONE;
		end
	endfunction

	// lowest selected sector, erased first
	function [4:0] low_idx;
		input [31:0] v;
		integer i;
		begin
			low_idx = 5'h00;
			for (i = 31; i >= 0; i = i - 1)
				if (v[i])
					low_idx = i[4:0];
		end
	endfunction

	fws_reset_sync u_rst (
		.clk   (clk),
		.nrst  (nrst),
		.rst_n (rst_n)
	);

	fws_nv_protect u_prot (
		.clk                     (clk),
		.rst_n                   (rst_n),
		.wr_stb                  (prot_wr_reg),
		.wr_addr                 (target_addr_low_reg),
		.wr_dlo                  (wdata0_low_reg),
		.wr_dhi                  (wdata0_high_reg),
		.nv_write_protect_reg    (nv_wp),
		.nv_access_protect_reg   (nv_ap0),
		.nv_protect_disable_reg  (nv_dis),
		.nv_protect_reenable_reg (nv_ren),
		.acc_on                  (prot_acc),
		.dbg_on                  (prot_dbg)
	);

	// a write is done once address and data are both held and no answer waits
	assign wr_fire = ~awready & ~wready & ~bvalid;
	assign hi_wr   = wr_fire & (awaddr_reg == `FWS_A_CTRL_HI);
	assign hv      = merge16(op_ctrl_high_reg, wdata_reg, wstrb_reg);
	// a start write keeps the select bits already stored, so "= 0x8000" works
	assign st_sel  = (hv | op_ctrl_high_reg) & `FWS_M_OPSEL;
	assign st_op   = op_dec(st_sel);
	assign sec_all = {sector_sel_high_reg, sector_sel_low_reg};
	assign stat    = {state_reg == S_PES, state_reg == S_PSUSP,
		state_reg == S_ESUSP, |(state_reg & (S_PROG | S_ERASE | S_SPR | S_PES))};

	// read decode, unmapped words answer slverr with zero data
	always @*
	begin
		rd_ok   = 1'b1;
		rd_data = 32'h00000000;
		case (araddr)
			`FWS_A_CTRL_LO:  rd_data = {16'h0000, op_ctrl_low_reg};
			`FWS_A_CTRL_HI:  rd_data = {16'h0000, op_ctrl_high_reg};
			`FWS_A_SEC_LO:   rd_data = {16'h0000, sector_sel_low_reg};
			`FWS_A_SEC_HI:   rd_data = {16'h0000, sector_sel_high_reg};
			`FWS_A_ADDR_LO:  rd_data = {16'h0000, target_addr_low_reg};
			`FWS_A_ADDR_HI:  rd_data = {16'h0000, target_addr_high_reg};
			`FWS_A_D0_LO:    rd_data = {16'h0000, wdata0_low_reg};
			`FWS_A_D0_HI:    rd_data = {16'h0000, wdata0_high_reg};
			`FWS_A_D1_LO:    rd_data = {16'h0000, wdata1_low_reg};
			`FWS_A_D1_HI:    rd_data = {16'h0000, wdata1_high_reg};
			`FWS_A_ERR:      rd_data = {16'h0000, error_reg};
			`FWS_A_STAT:     rd_data = {28'h0000000, stat};
			`FWS_A_NV_WP_LO: rd_data = {16'h0000, nv_wp[15:0]};
			`FWS_A_NV_WP_HI: rd_data = {16'h0000, nv_wp[31:16]};
			`FWS_A_NV_AP0:   rd_data = {16'h0000, nv_ap0};
			`FWS_A_NV_DIS:   rd_data = {16'h0000, nv_dis};
			`FWS_A_NV_REN:   rd_data = {16'h0000, nv_ren};
			default:         rd_ok = 1'b0;
		endcase
	end

	// bus slave, register file and operation sequencer share one process so
	// that hardware updates placed later win over a software write
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `FWS_RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rresp <= `FWS_RESP_OKAY;
			rdata <= 32'h00000000;
			awaddr_reg <= 8'h00;
			wdata_reg <= `FWS_RST_REG;
			wstrb_reg <= 2'h0;
			op_ctrl_low_reg <= `FWS_RST_REG;
			op_ctrl_high_reg <= `FWS_RST_REG;
			sector_sel_low_reg <= `FWS_RST_REG;
			sector_sel_high_reg <= `FWS_RST_REG;
			target_addr_low_reg <= `FWS_RST_REG;
			target_addr_high_reg <= `FWS_RST_REG;
			wdata0_low_reg <= `FWS_RST_REG;
			wdata0_high_reg <= `FWS_RST_REG;
			wdata1_low_reg <= `FWS_RST_REG;
			wdata1_high_reg <= `FWS_RST_REG;
			error_reg <= `FWS_RST_REG;
			saved_sel_reg <= `FWS_RST_REG;
			prog_dw_reg <= 1'b0;
			state_reg <= S_IDLE;
			cnt_reg <= 16'h0000;
			prot_wr_reg <= 1'b0;
			fl_prog_stb <= 1'b0;
			fl_dword <= 1'b0;
			fl_addr <= 32'h00000000;
			fl_data <= 64'h0000000000000000;
			fl_erase_stb <= 1'b0;
			fl_erase_sector <= 5'h00;
			busy <= 1'b0;
			acc_prot_on <= 1'b0;
			dbg_prot_on <= 1'b0;
		end
		else
		begin
			fl_prog_stb <= 1'b0;
			fl_erase_stb <= 1'b0;
			prot_wr_reg <= 1'b0;
			busy <= stat[0];
			acc_prot_on <= prot_acc;
			dbg_prot_on <= prot_dbg;
			// write address and data are taken independently
			if (awvalid && awready)
			begin
				awaddr_reg <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				wdata_reg <= wdata[15:0];
				wstrb_reg <= wstrb[1:0];
				wready <= 1'b0;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (wr_fire)
			begin
				bvalid <= 1'b1;
				bresp <= `FWS_RESP_OKAY;
				case (awaddr_reg)
					`FWS_A_CTRL_LO: op_ctrl_low_reg <= merge16(op_ctrl_low_reg, wdata_reg, wstrb_reg);
					`FWS_A_CTRL_HI: bresp <= `FWS_RESP_OKAY;
					`FWS_A_SEC_LO:  sector_sel_low_reg <= merge16(sector_sel_low_reg, wdata_reg, wstrb_reg);
					`FWS_A_SEC_HI:  sector_sel_high_reg <= merge16(sector_sel_high_reg, wdata_reg, wstrb_reg);
					`FWS_A_ADDR_LO: target_addr_low_reg <= merge16(target_addr_low_reg, wdata_reg, wstrb_reg);
					`FWS_A_ADDR_HI: target_addr_high_reg <= merge16(target_addr_high_reg, wdata_reg, wstrb_reg);
					`FWS_A_D0_LO:   wdata0_low_reg <= merge16(wdata0_low_reg, wdata_reg, wstrb_reg);
					`FWS_A_D0_HI:   wdata0_high_reg <= merge16(wdata0_high_reg, wdata_reg, wstrb_reg);
					`FWS_A_D1_LO:   wdata1_low_reg <= merge16(wdata1_low_reg, wdata_reg, wstrb_reg);
					`FWS_A_D1_HI:   wdata1_high_reg <= merge16(wdata1_high_reg, wdata_reg, wstrb_reg);
					`FWS_A_ERR:     error_reg <= error_reg & ~(wdata_reg & {16{wstrb_reg[0]}});
					`FWS_A_STAT, `FWS_A_NV_WP_LO, `FWS_A_NV_WP_HI, `FWS_A_NV_AP0,
					`FWS_A_NV_DIS, `FWS_A_NV_REN: bresp <= `FWS_RESP_OKAY;
					default:        bresp <= `FWS_RESP_SLVERR;
				endcase
			end
			// read answer follows the address by one edge
			if (arvalid && arready)
			begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_ok ? `FWS_RESP_OKAY : `FWS_RESP_SLVERR;
			end
			if (rvalid && rready)
			begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
			// control writes steer the sequencer; without a start nothing launches
			if (hi_wr)
			begin
				case (state_reg)
					S_PES:
						op_ctrl_high_reg <= (hv & ~(`FWS_M_SUSPEND_REQ | `FWS_M_SER)) | `FWS_M_START;
					S_PROG, S_ERASE:
					begin
						if (hv[`FWS_B_SUSPEND_REQ])
						begin
							state_reg <= (state_reg == S_ERASE) ? S_ESUSP : S_PSUSP;
							op_ctrl_high_reg <= hv & ~`FWS_M_START;
						end
						else
							op_ctrl_high_reg <= hv | `FWS_M_START;
					end
					S_SPR:
						op_ctrl_high_reg <= hv | `FWS_M_START;
					S_IDLE, S_ESUSP, S_PSUSP:
					begin
						if (!hv[`FWS_B_START] || hv[`FWS_B_SUSPEND_REQ] || st_op == `FWS_OP_NONE)
							op_ctrl_high_reg <= hv & ~`FWS_M_START;
						else if (state_reg == S_IDLE)
						begin
							op_ctrl_high_reg <= hv | st_sel;
							saved_sel_reg <= st_sel;
							prog_dw_reg <= (st_op == `FWS_OP_DWORD);
							cnt_reg <= 16'h0000;
							if (st_op == `FWS_OP_ERASE)
								state_reg <= S_ERASE;
							else if (st_op == `FWS_OP_SPR)
								state_reg <= S_SPR;
							else
								state_reg <= S_PROG;
						end
						else if (st_sel == saved_sel_reg)
						begin
							op_ctrl_high_reg <= hv | st_sel;
							state_reg <= (state_reg == S_ESUSP) ? S_ERASE : S_PROG;
						end
						else if (state_reg == S_ESUSP && !st_sel[`FWS_B_SER] &&
							(st_op == `FWS_OP_WORD || st_op == `FWS_OP_DWORD))
						begin
							op_ctrl_high_reg <= (hv | st_sel) & ~`FWS_M_SUSPEND_REQ;
							prog_dw_reg <= (st_op == `FWS_OP_DWORD);
							cnt_reg <= 16'h0000;
							state_reg <= S_PES;
						end
						else
						begin
							// a changed setup at resume abandons the operation
							op_ctrl_high_reg <= `FWS_RST_REG;
							state_reg <= S_IDLE;
							error_reg[`FWS_B_ERR_RES] <= 1'b1;
						end
					end
					default:
						state_reg <= S_IDLE;
				endcase
			end
			// running operations pause for the one cycle of a control write
			else if (state_reg == S_PROG || state_reg == S_PES || state_reg == S_SPR)
			begin
				cnt_reg <= cnt_reg + 16'h0001;
				if ({16'h0000, cnt_reg} == PROG_LAST)
				begin
					cnt_reg <= 16'h0000;
					op_ctrl_high_reg <= `FWS_RST_REG;
					state_reg <= (state_reg == S_PES) ? S_ESUSP : S_IDLE;
					if (state_reg == S_SPR)
						prot_wr_reg <= 1'b1;
					else
					begin
						fl_prog_stb <= 1'b1;
						fl_dword <= prog_dw_reg;
						fl_addr <= {target_addr_high_reg, target_addr_low_reg[15:3],
							target_addr_low_reg[`FWS_ADDR_BIT2] & ~prog_dw_reg,
							target_addr_low_reg[1:0]};
						fl_data <= {prog_dw_reg ? {wdata1_high_reg, wdata1_low_reg} : 32'h00000000,
							wdata0_high_reg, wdata0_low_reg};
					end
				end
			end
			else if (state_reg == S_ERASE)
			begin
				// sectors are erased lowest first and their bits cleared as they finish
				if (sec_all == 32'h00000000)
				begin
					op_ctrl_high_reg <= `FWS_RST_REG;
					state_reg <= S_IDLE;
				end
				else if ({16'h0000, cnt_reg} == ERASE_LAST)
				begin
					cnt_reg <= 16'h0000;
					fl_erase_stb <= 1'b1;
					fl_erase_sector <= low_idx(sec_all);
					{sector_sel_high_reg, sector_sel_low_reg} <= sec_all & (sec_all - 32'h00000001);
				end
				else
					cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end
endmodule // fws_flash_seq

/* tb/fws_flash_seq_monitor.sv */
// assertions on the bus port and flash strobes of the flash write sequencer
// bound to every fws_flash_seq instance, sees only its ports
module fws_flash_seq_monitor #(
	parameter PROG_CYCLES  = 16,
	parameter ERASE_CYCLES = 64
) (
	input wire        clk,
	input wire        nrst,
	input wire        awvalid,
	input wire        awready,
	input wire        wvalid,
	input wire        wready,
	input wire [1:0]  bresp,
	input wire        bvalid,
	input wire        bready,
	input wire        arvalid,
	input wire        arready,
	input wire [31:0] rdata,
	input wire [1:0]  rresp,
	input wire        rvalid,
	input wire        rready,
	input wire        fl_prog_stb,
	input wire        fl_dword,
	input wire [31:0] fl_addr,
	input wire [63:0] fl_data,
	input wire        fl_erase_stb,
	input wire        busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// both halves of a write taken at one edge
	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	// response offered but not yet taken
	sequence resp_wait;
		bvalid && !bready;
	endsequence

	wr_resp_a: assert property (wr_taken |-> ##[1:2] bvalid) else $error("write not answered");
	resp_hold_a: assert property (resp_wait |=> bvalid && $stable(bresp)) else $error("bresp moved");
	wr_block_a: assert property (bvalid |-> !awready && !wready) else $error("accepts during resp");
	rd_resp_a: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
	rd_half_a: assert property (rvalid |-> rdata[31:16] == 16'h0000) else $error("wide read data");
	rd_err_a: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0) else $error("error data");
	prog_pulse_a: assert property (fl_prog_stb |=> !fl_prog_stb) else $error("program pulse long");
	prog_run_a: assert property (fl_prog_stb |-> $past(busy)) else $error("program while idle");
	word_data_a: assert property (fl_prog_stb && !fl_dword |-> fl_data[63:32] == 32'h0) else $error("word hi");
	dword_align_a: assert property (fl_prog_stb && fl_dword |-> !fl_addr[2]) else $error("dword align");
	erase_pulse_a: assert property (fl_erase_stb |=> !fl_erase_stb) else $error("erase pulse long");
endmodule // fws_flash_seq_monitor

bind fws_flash_seq fws_flash_seq_monitor #(
	.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)
) u_mon (.clk, .nrst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fl_prog_stb, .fl_dword,
	.fl_addr, .fl_data, .fl_erase_stb, .busy);

/* tb/tb_top.sv */
// self-checking bench for the flash write sequencer
// drives the bus port itself and records every flash strobe
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	wire         awready, wready, bvalid, arready, rvalid, fl_prog_stb, fl_dword;
	wire         fl_erase_stb, busy, acc_prot_on, dbg_prot_on;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata, fl_addr;
	wire  [63:0] fl_data;
	wire  [4:0]  fl_erase_sector;
	logic [1:0]  br;
	logic [15:0] rv, em;
	logic [31:0] pa;
	logic [63:0] pd;
	logic        pdw;
	int          miscompares, check_count, np, ne, n;

	// short counts keep erase and program runs brief
	fws_flash_seq #(.PROG_CYCLES(8), .ERASE_CYCLES(12)) u_dut (.clk, .nrst, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fl_prog_stb,
		.fl_dword, .fl_addr, .fl_data, .fl_erase_stb, .fl_erase_sector, .busy,
		.acc_prot_on, .dbg_prot_on);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// capture strobes so scenarios judge them after the operation ends
	always @(posedge clk)
	begin
		if (fl_prog_stb === 1'b1)
		begin
			np++;
			pa = fl_addr;
			pd = fl_data;
			pdw = fl_dword;
		end
		if (fl_erase_stb === 1'b1)
		begin
			ne++;
			em = em | (16'h0001 << fl_erase_sector);
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one write, address and data offered together; bready held until bvalid
	task automatic w(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		br = bresp;
		bready <= 1'b0;
	endtask

	task automatic r(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata[15:0];
		br = rresp;
		rready <= 1'b0;
	endtask

	// busy lags the start by a cycle, so let it rise before polling
	task automatic idle;
		repeat (3) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
	endtask

	task automatic load(input logic [15:0] ah, al, d0l, d0h, d1l, d1h);
		w(8'h10, al);
		w(8'h14, ah);
		w(8'h18, d0l);
		w(8'h1c, d0h);
		w(8'h20, d1l);
		w(8'h24, d1h);
	endtask

	task automatic t_word;
		n = np;
		w(8'h04, 16'h2080);
		load(16'h0002, 16'h5554, 16'haaaa, 16'h1234, 16'h9999, 16'h7777);
		w(8'h04, 16'h8000);
		idle;
		chk(np - n, 1, "word count");
		chk(pa, 32'h00025554, "word addr");
		chk(pd, 64'h1234aaaa, "word data");
		chk(pdw, 0, "word size");
		r(8'h04);
		chk(rv, 0, "ctrl after op");
	endtask

	// suspend a running word program, then resume it with its select restored
	task automatic t_psusp;
		n = np;
		w(8'h04, 16'h2080);
		w(8'h04, 16'h8000);
		w(8'h04, 16'h6080);
		repeat (20) @(posedge clk);
		r(8'h2c);
		chk(rv[2], 1, "program suspended");
		chk(np - n, 0, "program ran in suspend");
		w(8'h04, 16'h2080);
		w(8'h04, 16'h8000);
		idle;
		chk(np - n, 1, "program resumed");
		chk(pa, 32'h00025554, "resumed addr");
	endtask

	task automatic t_dword;
		w(8'h04, 16'h1080);
		load(16'h0003, 16'h555c, 16'h55aa, 16'h55aa, 16'haa55, 16'haa55);
		w(8'h04, 16'h8000);
		idle;
		chk(pa, 32'h00035558, "dword addr");
		chk(pd, 64'haa55aa5555aa55aa, "dword data");
		chk(pdw, 1, "dword size");
	endtask

	task automatic t_cancel;
		n = np;
		w(8'h04, 16'h2080);
		w(8'h04, 16'h0000);
		w(8'h04, 16'h8000);
		idle;
		chk(np - n, 0, "cancelled op ran");
		w(8'h04, 16'h6080);
		w(8'h04, 16'hc000);
		idle;
		chk(np - n, 0, "start with suspend ran");
		r(8'h04);
		chk(rv[15], 0, "start kept");
		w(8'h04, 16'h0000);
	endtask

	task automatic t_erase;
		em = 0;
		n = ne;
		w(8'h04, 16'h0880);
		w(8'h08, 16'h0003);
		w(8'h04, 16'h8000);
		idle;
		chk(em, 16'h0003, "erased set");
		chk(ne - n, 2, "erase count");
		r(8'h08);
		chk(rv, 0, "sectors left");
		r(8'h0c);
		chk(rv, 0, "sectors high left");
	endtask

	task automatic t_suspend_req;
		em = 0;
		n = np;
		w(8'h04, 16'h0880);
		w(8'h08, 16'h0006);
		w(8'h04, 16'h8000);
		w(8'h04, 16'hc880);
		r(8'h2c);
		chk(rv[1], 1, "erase suspended");
		w(8'h04, 16'h0000);
		w(8'h04, 16'h2080);
		load(16'h0004, 16'h5554, 16'haaaa, 16'h5555, 16'h0000, 16'h0000);
		w(8'h04, 16'ha080);
		w(8'h04, 16'he080);
		r(8'h04);
		chk(rv & 16'h4800, 0, "erase or suspend set");
		idle;
		chk(np - n, 1, "program in suspend");
		chk(pa, 32'h00045554, "suspend prog addr");
		chk(em, 0, "erase ran in suspend");
		r(8'h2c);
		chk(rv[1], 1, "suspend lost");
		w(8'h04, 16'h0800);
		w(8'h04, 16'h8000);
		idle;
		chk(em, 16'h0006, "resumed erase");
	endtask

	task automatic t_abort;
		n = ne;
		w(8'h04, 16'h0880);
		w(8'h08, 16'h0004);
		w(8'h04, 16'h8000);
		w(8'h04, 16'hc880);
		w(8'h04, 16'h0100);
		w(8'h04, 16'h8000);
		idle;
		r(8'h28);
		chk(rv[0], 1, "resume error");
		repeat (40) @(posedge clk);
		chk(ne - n, 0, "aborted erase ran");
		w(8'h28, 16'h0001);
		r(8'h28);
		chk(rv[0], 0, "error kept");
	endtask

	task automatic sp(input logic [15:0] a, input logic [15:0] dl, input logic [15:0] dh);
		w(8'h04, 16'h0100);
		load(16'h000e, a, dl, dh, 16'h0000, 16'h0000);
		w(8'h04, 16'h8000);
		idle;
	endtask

	task automatic t_prot;
		r(8'h3c);
		chk(rv, 16'hffff, "disable reset");
		sp(16'hdfb4, 16'hfff0, 16'hffff);
		r(8'h30);
		chk(rv, 16'hfff0, "write protect");
		sp(16'hdfb8, 16'hfffc, 16'hffff);
		r(8'h38);
		chk(rv, 16'hfffc, "access reg");
		chk({acc_prot_on, dbg_prot_on}, 2'b11, "prot on");
		sp(16'hdfbc, 16'hfffe, 16'hffff);
		r(8'h3c);
		chk(rv, 16'hfffe, "disable bit0");
		chk(acc_prot_on, 0, "prot disabled");
		sp(16'hdfbc, 16'hfffc, 16'hffff);
		r(8'h3c);
		chk(rv, 16'hfffe, "early disable bit1");
		sp(16'hdfbc, 16'hffff, 16'hfffe);
		r(8'h40);
		chk(rv, 16'hfffe, "reenable bit0");
		chk(acc_prot_on, 1, "prot again");
	endtask

	task automatic t_bus;
		r(8'h44);
		chk({br, rv}, {2'b10, 16'h0000}, "unmapped read");
		w(8'h44, 16'h0001);
		chk(br, 2'b10, "unmapped write");
		w(8'h38, 16'h0000);
		chk(br, 2'b00, "read-only write");
		r(8'h38);
		chk(rv, 16'hfffc, "read-only changed");
		wstrb <= 4'h1;
		w(8'h00, 16'hffa5);
		wstrb <= 4'h3;
		r(8'h00);
		chk(rv, 16'h00a5, "low byte write");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'h3;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_word;
		t_psusp;
		t_dword;
		t_cancel;
		t_erase;
		t_suspend_req;
		t_abort;
		t_prot;
		t_bus;
		finish_test;
	end

	// the sequence needs about seven hundred cycles; this cuts a hang
	initial
	begin
		#100us;
		miscompares++;
		finish_test;
	end
endmodule // tb_top
